// ===== dsm_bus_host.sv
// Fieldbus master model that reaches the sequencer registers over AHB-Lite.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module dsm_bus_host (
  // Clock and bus answer.
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request.
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  // The bus starts idle so nothing is requested during reset.
  initial begin
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0000_0000;
  end

  // Address phase is held until hready, then the data phase until hready.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
    // A released data bus must not keep looking valid.
    hwdata <= ~wd;
  endtask

  // Single word write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(a, 1'h1, d, unused);
  endtask

  // Single word read; data taken at the edge that ends the data phase.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(a, 1'h0, 32'h0000_0000, d);
  endtask
endmodule

// ===== dsm_pkg.sv
// Shared constants and types for the drive operating-state sequencer.
// Assumes a single 200 MHz clock domain and an AHB-Lite register slave.
package dsm_pkg;
  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CONF = 8'h04;
  localparam logic [7:0] A_REF  = 8'h08;
  localparam logic [7:0] A_CFGP = 8'h0C;
  localparam logic [7:0] A_ADJP = 8'h10;
  localparam logic [7:0] A_TUNE = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // Control word bit positions.
  localparam int CW_SON  = 0;
  localparam int CW_EV   = 1;
  localparam int CW_QSN  = 2;
  localparam int CW_EO   = 3;
  localparam int CW_FRST = 7;
  localparam int CW_HALT = 8;
  // Configuration register bit positions.
  localparam int CF_DOS  = 0;
  localparam int CF_QSB  = 1;
  localparam int CF_REFC = 2;
  localparam int CF_ERRR = 3;
  // Reset values.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [3:0]  CONF_RST = 4'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Timing: figures in ns, converted to cycles rounded up.
  localparam int CLK_NS   = 5;
  localparam int RAMP_NS  = 2000;
  localparam int FAST_NS  = 500;
  localparam int FAULT_NS = 100;
  localparam logic [15:0] RAMP_CYC  = 16'((RAMP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] FAST_CYC  = 16'((FAST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] FAULT_CYC = 16'((FAULT_NS + CLK_NS - 1) / CLK_NS);
  // Operating states; the code equals the reported state number, except ST_INIT, which is reported as ST_SOD.
  typedef enum logic [3:0] {
    ST_INIT = 4'h1, ST_SOD = 4'h2, ST_RTSO = 4'h3, ST_SO = 4'h4,
    ST_OE   = 4'h5, ST_QSA = 4'h6, ST_FRA  = 4'h7, ST_FLT = 4'h8
  } dsm_state_t;
endpackage

// ===== dsm_ramp.sv
// Down-counting stop timer standing in for the deceleration ramp.
// Assumes the controller issues one start at a time; start wins over counting.
`timescale 1ns/1ps
module dsm_ramp (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control from the sequencer.
  dsm_ramp_if.tmr   rif
);
  logic [15:0] cnt_q;   // Cycles left in the running stop.
  logic        done_q;  // Completion pulse.

  // Abort wins so a cancelled stop never reports completion.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (rif.abort) begin
        cnt_q <= 16'h0000;
      end else if (rif.start) begin
        cnt_q <= rif.cycles;
      end else if (cnt_q != 16'h0000) begin
        cnt_q  <= cnt_q - 16'h0001;
        done_q <= (cnt_q == 16'h0001);
      end
    end
  end

  assign rif.busy = (cnt_q != 16'h0000);
  assign rif.done = done_q;
endmodule

// ===== dsm_ramp_if.sv
// Carrier between the sequencer and its stop-ramp timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dsm_ramp_if;
  logic        start;   // Load the timer and begin a stop.
  logic        abort;   // Drop a running stop at once.
  logic [15:0] cycles;  // Stop length in clock cycles.
  logic        busy;    // A stop is running.
  logic        done;    // One-cycle pulse when a stop completes.
  modport ctl  (output start, abort, cycles, input busy, done);
  modport tmr  (input start, abort, cycles, output busy, done);
endinterface

// ===== dsm_sync.sv
// Two-flop synchroniser for pin inputs, one chain per bit.
// Assumes inputs are asynchronous to hclk.
`timescale 1ns/1ps
module dsm_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Data.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;  // First stage, read only by the second.

  // Each bit gets its own chain so that no bit gates another.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_q[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        s1_q[i] <= d[i];
        q[i]    <= s1_q[i];
      end
    end
  end
endmodule

// ===== dsm_top.sv
// Drive operating-state sequencer with an AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, and asynchronous
// pin inputs for mains presence, error detection, freewheel and channel.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module dsm_top
  import dsm_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins from the power section and terminals.
  input  wire logic        mains_ok,
  input  wire logic        error_detect,
  input  wire logic        freewheel_stop,
  input  wire logic        channel_valid,
  // Drive outputs.
  output logic             contactor_close,
  output logic             power_stage_ready,
  output logic             drive_unlocked,
  output logic             motor_power_on,
  output logic             coast_active,
  output logic             tune_active,
  output logic      [3:0]  state_word
);
  dsm_ramp_if rif ();

  // Synchronised pin inputs.
  logic [3:0] pins_s;
  logic       pwr_s;    // Power stage supply present.
  logic       err_s;    // Error detected.
  logic       fw_s;     // Freewheel stop request.
  logic       chan_s;   // Command channel valid.

  // Bus pipeline state.
  logic       aph_q;    // A data phase is in progress.
  logic [7:0] adr_q;    // Latched byte offset.
  logic       wr_q;     // Latched direction.

  // Software registers.
  logic [15:0] ctrl_q;      // Control word.
  logic [3:0]  conf_q;      // Stop selectors and options.
  logic [15:0] ref_q;       // Speed reference.
  logic        ref_seen_q;  // Reference received at least once.
  logic [15:0] cfgp_q;      // Configuration parameter.
  logic [15:0] adjp_q;      // Adjustment parameter.
  logic        cfg_rej_q;   // Last configuration write refused.
  logic        tune_rej_q;  // Last tuning start refused.

  // Sequencer state.
  dsm_state_t st_q, st_d;
  logic       stop_q, stop_d;  // Ramp stop running toward switched on.
  logic       coast_set;       // Freewheel disable taken this cycle.

  // Write strobes, valid during the data phase.
  logic we, wr_ctrl, wr_conf, wr_ref, wr_cfgp, wr_adjp, wr_tune;
  logic cfg_ok;     // Configuration writes allowed in this state.
  logic frst_edge;  // Fault reset bit goes from 0 to 1.

  // Decoded commands.
  logic c_dis_v, c_qs, c_shut, c_son, c_en, c_dis_op;

  dsm_sync #(.W(4)) dsm_sync_inst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({channel_valid, freewheel_stop, error_detect, mains_ok}),
    .q       (pins_s)
  );
  assign {chan_s, fw_s, err_s, pwr_s} = pins_s;

  dsm_ramp dsm_ramp_inst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rif     (rif)
  );

  // Address phase capture; zero wait states, so hready is always ours.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= 1'b0;
      adr_q <= 8'h00;
      wr_q  <= 1'b0;
    end else if (hready) begin
      aph_q <= hsel & htrans[1];
      adr_q <= haddr[7:0];
      wr_q  <= hwrite;
    end
  end

  assign we      = aph_q & wr_q;
  assign wr_ctrl = we & (adr_q == A_CTRL);
  assign wr_conf = we & (adr_q == A_CONF);
  assign wr_ref  = we & (adr_q == A_REF);
  assign wr_cfgp = we & (adr_q == A_CFGP);
  assign wr_adjp = we & (adr_q == A_ADJP);
  assign wr_tune = we & (adr_q == A_TUNE);

  // Only the transition of the stored bit counts, never its level.
  assign frst_edge = wr_ctrl & hwdata[CW_FRST] & ~ctrl_q[CW_FRST];

  // Configuration is refused while running, stopping or reacting.
  assign cfg_ok = (st_q == ST_SOD) | (st_q == ST_RTSO) | (st_q == ST_SO)
                | (st_q == ST_FLT) | (st_q == ST_INIT);

  // Read data is sampled in the address phase so it leaves a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          A_CTRL:  hrdata <= {16'h0000, ctrl_q};
          A_CONF:  hrdata <= {28'h000_0000, conf_q};
          A_REF:   hrdata <= {16'h0000, ref_q};
          A_CFGP:  hrdata <= {16'h0000, cfgp_q};
          A_ADJP:  hrdata <= {16'h0000, adjp_q};
          A_TUNE:  hrdata <= {31'h0000_0000, tune_active};
          // The state code owns the low nibble; flags sit above it, never over it.
          A_STAT:  hrdata <= {19'h0_0000, tune_rej_q, cfg_rej_q, ref_seen_q,
                              tune_active, coast_active, motor_power_on,
                              drive_unlocked, power_stage_ready,
                              contactor_close, state_word};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control, options and reference registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= CTRL_RST;
      conf_q     <= CONF_RST;
      ref_q      <= WORD_RST;
      ref_seen_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[15:0];
      end
      if (wr_conf) begin
        conf_q <= hwdata[3:0];
      end
      if (wr_ref) begin
        ref_q      <= hwdata[15:0];
        ref_seen_q <= 1'b1;
      end
    end
  end

  // Parameter registers; adjustment writes are always accepted.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfgp_q    <= WORD_RST;
      adjp_q    <= WORD_RST;
      cfg_rej_q <= 1'b0;
    end else begin
      if (wr_cfgp) begin
        cfg_rej_q <= ~cfg_ok;
        if (cfg_ok) begin
          cfgp_q <= hwdata[15:0];
        end
      end
      if (wr_adjp) begin
        adjp_q <= hwdata[15:0];
      end
    end
  end

  // Command decode from the stored control word.
  always_comb begin
    c_dis_v  = ~ctrl_q[CW_EV];
    c_qs     = ctrl_q[CW_EV] & ~ctrl_q[CW_QSN];
    c_shut   = ctrl_q[CW_EV] & ctrl_q[CW_QSN] & ~ctrl_q[CW_SON];
    c_son    = ctrl_q[CW_EV] & ctrl_q[CW_QSN] & ctrl_q[CW_SON];
    c_en     = c_son & ctrl_q[CW_EO];
    c_dis_op = c_son & ~ctrl_q[CW_EO];
  end

  // Next-state logic; an error outranks every command.
  always_comb begin
    st_d       = st_q;
    stop_d     = stop_q;
    coast_set  = 1'b0;
    rif.start  = 1'b0;
    rif.abort  = 1'b0;
    rif.cycles = FAULT_CYC;
    if (err_s && st_q != ST_FRA && st_q != ST_FLT && st_q != ST_INIT) begin
      st_d      = ST_FRA;
      rif.start = 1'b1;
    end else begin
      unique case (st_q)
        ST_INIT: st_d = ST_SOD;
        ST_SOD: begin
          if (c_shut) begin
            st_d = ST_RTSO;
          end
        end
        ST_RTSO: begin
          if (c_dis_v || c_qs) begin
            st_d = ST_SOD;
          end else if (c_son && pwr_s) begin
            st_d = ST_SO;
          end
        end
        ST_SO: begin
          if (c_dis_v || c_qs || fw_s || (wr_cfgp && cfg_ok)) begin
            st_d = ST_SOD;
          end else if (c_shut) begin
            st_d = ST_RTSO;
          end else if (c_en && chan_s && (!conf_q[CF_REFC] || ref_seen_q)) begin
            st_d = ST_OE;
          end
        end
        ST_OE: begin
          if (c_dis_v || fw_s) begin
            st_d      = ST_SOD;
            rif.abort = 1'b1;
          end else if (c_qs) begin
            st_d       = ST_QSA;
            rif.start  = 1'b1;
            rif.cycles = FAST_CYC;
          end else if (c_shut) begin
            st_d      = ST_RTSO;
            rif.abort = 1'b1;
          end else if (stop_q) begin
            // A fresh enable cancels the ramp and keeps running.
            if (c_en) begin
              rif.abort = 1'b1;
              stop_d    = 1'b0;
            end else if (rif.done) begin
              st_d = ST_SO;
            end
          end else if (c_dis_op) begin
            if (conf_q[CF_DOS]) begin
              stop_d     = 1'b1;
              rif.start  = 1'b1;
              rif.cycles = RAMP_CYC;
            end else begin
              st_d      = ST_SO;
              coast_set = 1'b1;
            end
          end
        end
        ST_QSA: begin
          if (c_dis_v || fw_s) begin
            st_d      = ST_SOD;
            rif.abort = 1'b1;
          end else if (rif.done && !conf_q[CF_QSB]) begin
            st_d = ST_SOD;
          end
        end
        ST_FRA: begin
          if (rif.done) begin
            st_d = ST_FLT;
          end
        end
        ST_FLT: begin
          if (frst_edge && !err_s) begin
            st_d = ST_SOD;
          end
        end
      endcase
    end
    if (st_d != ST_OE) begin
      stop_d = 1'b0;
    end
  end

  // State register; the reported word never shows the init state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= ST_INIT;
      stop_q     <= 1'b0;
      state_word <= ST_SOD;
    end else begin
      st_q       <= st_d;
      stop_q     <= stop_d;
      state_word <= (st_d == ST_INIT) ? ST_SOD : st_d;
    end
  end

  // Power outputs follow the state one cycle later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      contactor_close   <= 1'b0;
      power_stage_ready <= 1'b0;
      drive_unlocked    <= 1'b0;
      motor_power_on    <= 1'b0;
    end else begin
      contactor_close   <= (st_q == ST_SO) | (st_q == ST_OE) | (st_q == ST_QSA);
      power_stage_ready <= (st_q == ST_SO) | (st_q == ST_OE) | (st_q == ST_QSA);
      drive_unlocked    <= (st_q == ST_OE) | ((st_q == ST_QSA) & rif.busy);
      // Halt or a zero reference cuts torque without leaving the state.
      motor_power_on    <= ((st_q == ST_OE) & ~ctrl_q[CW_HALT] & (ref_q != WORD_RST))
                         | ((st_q == ST_QSA) & rif.busy)
                         | ((st_q == ST_FRA) & conf_q[CF_ERRR] & rif.busy);
    end
  end

  // Coast flag and tuning requests; tuning drops when leaving operation.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coast_active <= 1'b0;
      tune_active  <= 1'b0;
      tune_rej_q   <= 1'b0;
    end else begin
      if (coast_set) begin
        coast_active <= 1'b1;
      end else if (st_d == ST_OE) begin
        coast_active <= 1'b0;
      end
      if (st_q != ST_OE) begin
        tune_active <= 1'b0;
      end else if (wr_tune) begin
        tune_active <= hwdata[0];
      end
      if (wr_tune && hwdata[0]) begin
        tune_rej_q <= (st_q != ST_OE);
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_INIT_LEAVES: assert property ((st_q == ST_INIT) |=> (st_q == ST_SOD) && (state_word != 4'h1))
    else $error("init state did not settle in disabled");
  AST_SOD_SAFE: assert property ((st_q == ST_SOD) && $past(st_q) == ST_SOD |-> !contactor_close && !power_stage_ready && !motor_power_on)
    else $error("disabled state drives power");
  AST_RTSO_MAINS: assert property ((st_q == ST_RTSO) && (st_d == ST_SO) |-> pwr_s)
    else $error("switched on without mains");
  AST_SO_OUT: assert property ((st_q == ST_SO) |=> contactor_close && power_stage_ready && !motor_power_on)
    else $error("switched on outputs wrong");
  AST_CFG_SO: assert property ((st_q == ST_SO) && wr_cfgp && !err_s |=> (st_q == ST_SOD))
    else $error("configuration write did not disable");
  AST_HALT: assert property ((st_q == ST_OE) && (ctrl_q[CW_HALT] || ref_q == WORD_RST) |=> !motor_power_on)
    else $error("motor powered under halt or zero reference");
  AST_TUNE_OE: assert property ($rose(tune_active) |-> $past(st_q) == ST_OE)
    else $error("tuning started outside operation");
  AST_QSA_CFG: assert property ((st_q == ST_QSA) && wr_cfgp |=> $stable(cfgp_q) && cfg_rej_q)
    else $error("configuration written in quick stop");
  AST_FLT_OFF: assert property ((st_q == ST_FLT) ##1 (st_q == ST_FLT) |-> !power_stage_ready && !drive_unlocked && !motor_power_on)
    else $error("fault state drives power");
  AST_FRST_EDGE: assert property ((st_q == ST_FLT) && (st_d == ST_SOD) |->
    wr_ctrl && hwdata[CW_FRST] && !ctrl_q[CW_FRST] && !err_s)
    else $error("fault left without reset edge");
  AST_FRA_TIME: assert property ($rose(st_q == ST_FRA) |-> ##[1:30] (st_q != ST_FRA))
    else $error("fault reaction did not end in time");
endmodule

// ===== dsm_top_bench.sv
// Self-checking bench for the drive operating-state sequencer.
// Assumes the bus host model drives every register access.
`timescale 1ns/1ps
module dsm_top_bench
  import dsm_pkg::*;
;
  logic        hclk, hresetn, mains_ok, error_detect, freewheel_stop, channel_valid;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic        hwrite, hreadyout, hresp;
  logic        contactor_close, power_stage_ready, drive_unlocked;
  logic        motor_power_on, coast_active, tune_active;
  logic [3:0]  state_word;
  int          error_cnt, num_checks;

  // Device under test; select and size are fixed for single word access.
  dsm_top dsm_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mains_ok(mains_ok),
    .error_detect(error_detect), .freewheel_stop(freewheel_stop),
    .channel_valid(channel_valid), .contactor_close(contactor_close),
    .power_stage_ready(power_stage_ready), .drive_unlocked(drive_unlocked),
    .motor_power_on(motor_power_on), .coast_active(coast_active),
    .tune_active(tune_active), .state_word(state_word));

  // Master on the far side of the register bus.
  dsm_bus_host dsm_bus_host_inst (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  // 200 MHz clock.
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end

  // One comparison; an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits a bounded number of cycles for a state, then compares.
  task automatic wait_st(input logic [3:0] s, input int n);
    int i;
    for (i = 0; i < n && state_word !== s; i++) @(posedge hclk);
    chk(state_word, s);
  endtask

  // Writes a control word and waits for the state it should lead to.
  task automatic go(input logic [31:0] c, input logic [3:0] s);
    dsm_bus_host_inst.wr(A_CTRL, c);
    wait_st(s, 20);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The transient init code must never reach the state word.
  always @(posedge hclk) begin
    if (hresetn === 1'h1 && state_word === 4'h1) begin
      error_cnt++;
      $display("unexpected at %0t: init state visible", $time);
    end
  end

  // Cuts a hang short; the whole sequence needs about a thousand cycles.
  initial begin
    #60_000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  // Main sequence.
  initial begin
    hresetn        = 1'h0;
    mains_ok       = 1'h0;
    error_detect   = 1'h0;
    freewheel_stop = 1'h0;
    channel_valid  = 1'h1;
    error_cnt      = 0;
    num_checks     = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    // Let the init state pass so the checks see settled outputs.
    repeat (2) @(posedge hclk);
    chk(state_word, ST_SOD);
    chk({contactor_close, power_stage_ready, motor_power_on}, 0);
    // Reference comes from the channel, coast on disable.
    dsm_bus_host_inst.wr(A_CONF, 32'h0000_0004);
    go(32'h0000_0006, ST_RTSO);
    chk(contactor_close, 0);
    dsm_bus_host_inst.wr(A_CFGP, 32'h0000_1234);
    dsm_bus_host_inst.rd(A_CFGP, d);
    chk(d, 32'h0000_1234);
    // Switch on is held back until the mains is present.
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_0007);
    repeat (10) @(posedge hclk);
    chk(state_word, ST_RTSO);
    mains_ok <= 1'h1;
    wait_st(ST_SO, 10);
    repeat (2) @(posedge hclk);
    chk({contactor_close, power_stage_ready, motor_power_on}, 3'h6);
    $display("test power up done");
    dsm_bus_host_inst.wr(A_ADJP, 32'h0000_0005);
    repeat (5) @(posedge hclk);
    chk(state_word, ST_SO);
    dsm_bus_host_inst.wr(A_CFGP, 32'h0000_0055);
    wait_st(ST_SOD, 10);
    repeat (2) @(posedge hclk);
    chk({contactor_close, power_stage_ready, motor_power_on}, 0);
    go(32'h0000_0006, ST_RTSO);
    go(32'h0000_0007, ST_SO);
    dsm_bus_host_inst.wr(A_TUNE, 32'h0000_0001);
    dsm_bus_host_inst.rd(A_STAT, d);
    chk({d[12], tune_active}, 2'h2);
    // Enable waits for a reference, then for a valid channel, each alone.
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_000F);
    repeat (10) @(posedge hclk);
    chk(state_word, ST_SO);
    channel_valid <= 1'h0;
    dsm_bus_host_inst.wr(A_REF, 32'h0000_0000);
    repeat (10) @(posedge hclk);
    chk(state_word, ST_SO);
    channel_valid <= 1'h1;
    wait_st(ST_OE, 10);
    repeat (2) @(posedge hclk);
    chk({drive_unlocked, motor_power_on}, 2'h2);
    dsm_bus_host_inst.wr(A_REF, 32'h0000_0064);
    repeat (4) @(posedge hclk);
    chk(motor_power_on, 1);
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_010F);
    repeat (6) @(posedge hclk);
    chk({state_word, motor_power_on}, {ST_OE, 1'h0});
    go(32'h0000_000F, ST_OE);
    dsm_bus_host_inst.wr(A_TUNE, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    chk(tune_active, 1);
    dsm_bus_host_inst.wr(A_TUNE, 32'h0000_0000);
    dsm_bus_host_inst.rd(A_STAT, d);
    chk(d[3:0], ST_OE);
    $display("test enable done");
    go(32'h0000_0007, ST_SO);
    repeat (2) @(posedge hclk);
    chk({coast_active, motor_power_on}, 2'h2);
    dsm_bus_host_inst.wr(A_CONF, 32'h0000_0005);
    go(32'h0000_000F, ST_OE);
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_0007);
    repeat (50) @(posedge hclk);
    chk(state_word, ST_OE);
    wait_st(ST_SO, RAMP_CYC + 20);
    $display("test disable done");
    go(32'h0000_000F, ST_OE);
    go(32'h0000_000B, ST_QSA);
    repeat (3) @(posedge hclk);
    chk(motor_power_on, 1);
    dsm_bus_host_inst.wr(A_CFGP, 32'h0000_0099);
    dsm_bus_host_inst.rd(A_CFGP, d);
    chk(d, 32'h0000_0055);
    wait_st(ST_SOD, FAST_CYC + 30);
    // Holding quick stop: only disable voltage, freewheel or an error leaves.
    dsm_bus_host_inst.wr(A_CONF, 32'h0000_0007);
    go(32'h0000_0006, ST_RTSO);
    go(32'h0000_0007, ST_SO);
    go(32'h0000_000F, ST_OE);
    go(32'h0000_000B, ST_QSA);
    repeat (FAST_CYC + 50) @(posedge hclk);
    chk(state_word, ST_QSA);
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_000F);
    repeat (10) @(posedge hclk);
    chk(state_word, ST_QSA);
    freewheel_stop <= 1'h1;
    wait_st(ST_SOD, 10);
    freewheel_stop <= 1'h0;
    // A disable voltage command also ends a held quick stop.
    go(32'h0000_0006, ST_RTSO);
    go(32'h0000_0007, ST_SO);
    go(32'h0000_000F, ST_OE);
    go(32'h0000_000B, ST_QSA);
    go(32'h0000_0000, ST_SOD);
    $display("test quick stop done");
    // This error response keeps the motor powered while it runs.
    dsm_bus_host_inst.wr(A_CONF, 32'h0000_0008);
    error_detect <= 1'h1;
    wait_st(ST_FRA, 10);
    repeat (2) @(posedge hclk);
    chk(motor_power_on, 1);
    wait_st(ST_FLT, FAULT_CYC + 10);
    repeat (2) @(posedge hclk);
    chk({power_stage_ready, drive_unlocked, motor_power_on}, 0);
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_0080);
    repeat (6) @(posedge hclk);
    chk(state_word, ST_FLT);
    error_detect <= 1'h0;
    repeat (6) @(posedge hclk);
    chk(state_word, ST_FLT);
    dsm_bus_host_inst.wr(A_CTRL, 32'h0000_0000);
    go(32'h0000_0080, ST_SOD);
    // The slave must still answer ready and OKAY after all that traffic.
    chk({hreadyout, hresp}, 2'h2);
    $display("test fault done");
    final_report();
  end
endmodule
